// ==== common/gpio_defines.svh ====
// Offsets, field positions, reset values and timing counts of the pad controller
// How it works
// - Drive-enable bit 1 makes pin an output
// - Output pin drives its level bit
// - Input level resynchronized, readable in either direction
// - Receiver off means the pin is not sampled
// - Alternate-function enable hands pin to peripheral
// - Reset leaves pads tri-stated, receivers off
// - Group register set at base plus 0x80*group
// - Drive-enable set strobe sets only marked bits
// - Drive-enable clear strobe clears only marked bits
// - Level set, clear, toggle strobes act bitwise
// - On-demand sync delays an input read two cycles
// - Always-sync field keeps eight-pin synchronizers running
// - Pad config per pin byte, selector per pair
// - Drive, receiver and pull combine per table
// - Pull direction follows the output level bit
// - Enabled driver switches the pull off
// - Local port first, APB second, no waits
// - Concurrent APB access stretched by one cycle
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ****************************************************************
// Group address map
// ****************************************************************
`define GP_GRP_LSB 7
`define GP_GRP_MSB 11
`define GP_OFF_DIR 7'h00
`define GP_OFF_DRV_SET 7'h08
`define GP_OFF_DRV_CLR 7'h04
`define GP_OFF_DRV_TGL 7'h0C
`define GP_OFF_OUT 7'h10
`define GP_OFF_LVL_SET 7'h18
`define GP_OFF_LVL_CLR 7'h14
`define GP_OFF_LVL_TGL 7'h1C
`define GP_OFF_IN 7'h20
`define GP_OFF_CTRL 7'h24
`define GP_OFF_SEL 7'h30
`define GP_OFF_CFG 7'h40

// ****************************************************************
// Decode fields of an offset
// ****************************************************************
`define GP_BANK_DIR 3'h0
`define GP_BANK_OUT 3'h1
`define GP_BANK_SEL 3'h3
`define GP_CFG_TOP 2'h2

// ****************************************************************
// Pad configuration byte fields
// ****************************************************************
`define GP_CFG_AFE 0
`define GP_CFG_RX 1
`define GP_CFG_PULL 2

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define GP_RST_WORD 32'h0000_0000
`define GP_RST_BYTE 8'h00
`define GP_SYNC_CYCLES 2'h2

`endif

// ==== common/gpio_pkg.sv ====
// Types shared by the pad controller files
package gpio_pkg;
  // Strobe action taken from offset bits [3:2] of the direction and level banks
  typedef enum logic [1:0] {
    ACT_WRITE,
    ACT_CLEAR,
    ACT_SET,
    ACT_TOGGLE
  } strobe_act_t;
endpackage

// ==== hw/gpio_input_sync.sv ====
// Two-stage input synchronizer whose stages load only while enabled
`include "gpio_defines.svh"
module gpio_input_sync
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pad side
  input wire logic [31:0] pad_in,
  input wire logic [31:0] sample_en,
  // Resynchronized level
  output logic [31:0] level
);

  logic [31:0] meta_reg;
  logic [31:0] level_reg;

  // Disabled stages hold, saving toggling power; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= `GP_RST_WORD;
      level_reg <= `GP_RST_WORD;
    end else begin
      meta_reg <= (meta_reg & ~sample_en) | (pad_in & sample_en);
      level_reg <= (level_reg & ~sample_en) | (meta_reg & sample_en);
    end
  end

  assign level = level_reg;

endmodule

// ==== hw/gpio_pad_controller.sv ====
// Pad controller for one group of 32 pins with APB and core local port access
`include "gpio_defines.svh"
module gpio_pad_controller
  import gpio_pkg::*;
#(
  parameter logic [4:0] GROUP_INDEX = 5'h00
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  // Core local port, single cycle, read data one cycle later
  input wire logic lp_valid,
  input wire logic lp_write,
  input wire logic [11:0] lp_addr,
  input wire logic [31:0] lp_wdata,
  input wire logic [3:0] lp_be,
  output logic [31:0] lp_rdata,
  // Pads
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pad_rx_en,
  output logic [31:0] pad_pull_en,
  output logic [31:0] pad_pull_up,
  // Peripheral side
  input wire logic [31:0] periph_out,
  input wire logic [31:0] periph_oe,
  output logic [127:0] alt_function_select
);

  // All checks below run on the one clock and stand down during reset
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] drive_enable_reg;
  logic [31:0] level_reg;
  logic [31:0] always_sync_reg;
  logic [7:0] pad_config_reg [32];
  logic [7:0] sel_reg [16];
  logic [1:0] wait_cnt_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic [31:0] lp_rdata_reg;
  logic [31:0] pad_out_reg, pad_oe_reg, rx_reg, pull_en_reg, pull_up_reg;
  logic [127:0] alt_sel_reg;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Strobes change only marked bits and zero bits keep their value; a plain write replaces every bit of an enabled byte lane
  function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] d,
                                         input logic [31:0] m, input strobe_act_t act);
    unique case (act)
      ACT_WRITE: apply = (old & ~m) | (d & m);
      ACT_CLEAR: apply = old & ~(d & m);
      ACT_SET: apply = old | (d & m);
      ACT_TOGGLE: apply = old ^ (d & m);
    endcase
  endfunction

  // ****************************************************************
  // Per-pin views of the configuration bytes
  // ****************************************************************
  logic [31:0] afe_vec, rx_vec, pull_vec, sync_level, always_pin;
  always_comb begin
    for (int p = 0; p < 32; p++) begin
      afe_vec[p] = pad_config_reg[p][`GP_CFG_AFE];
      rx_vec[p] = pad_config_reg[p][`GP_CFG_RX];
      pull_vec[p] = pad_config_reg[p][`GP_CFG_PULL];
    end
  end

  // Any nonzero byte of the always-sync word keeps its eight pins running
  assign always_pin = {{8{|always_sync_reg[31:24]}}, {8{|always_sync_reg[23:16]}},
                       {8{|always_sync_reg[15:8]}}, {8{|always_sync_reg[7:0]}}};

  // ****************************************************************
  // Access decode and arbitration
  // ****************************************************************
  wire [6:0] apb_off = paddr[`GP_GRP_LSB-1:0];
  wire [6:0] lp_off = lp_addr[`GP_GRP_LSB-1:0];
  wire apb_hit = paddr[`GP_GRP_MSB:`GP_GRP_LSB] == GROUP_INDEX;
  // Local port reaches only direction, level and input words
  wire lp_ok = (lp_addr[`GP_GRP_MSB:`GP_GRP_LSB] == GROUP_INDEX) && (lp_off <= `GP_OFF_IN);
  wire apb_access = psel & penable & ~pready_reg;
  wire apb_in_rd = apb_access & ~pwrite & apb_hit & (apb_off == `GP_OFF_IN);
  wire needs_sync = ~&always_pin;
  wire sync_done = wait_cnt_reg == `GP_SYNC_CYCLES;
  // Local port always wins; APB waits a cycle on collision
  wire apb_go = apb_access & ~lp_valid & (~apb_in_rd | ~needs_sync | sync_done);
  wire lp_wr = lp_valid & lp_write & lp_ok;
  wire demand = apb_in_rd & needs_sync;

  // Sampling only on pins whose configuration receiver bit is set, alternate-function pins included
  wire [31:0] sample_en = rx_vec & (always_pin | {32{demand}});

  gpio_input_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pad_in(pad_in),
    .sample_en(sample_en),
    .level(sync_level)
  );

  // ****************************************************************
  // Unified write port
  // ****************************************************************
  wire wr_en = lp_wr | (apb_go & pwrite & apb_hit);
  wire [6:0] wr_off = lp_wr ? lp_off : apb_off;
  wire [31:0] wr_data = lp_wr ? lp_wdata : pwdata;
  wire [31:0] wr_mask = lane_mask(lp_wr ? lp_be : pstrb);
  wire [3:0] wr_be = lp_wr ? lp_be : pstrb;
  wire strobe_act_t wr_act = strobe_act_t'(wr_off[3:2]);
  wire dir_hit = wr_en && wr_off[6:4] == `GP_BANK_DIR;
  wire out_hit = wr_en && wr_off[6:4] == `GP_BANK_OUT;
  wire ctrl_hit = wr_en && wr_off == `GP_OFF_CTRL;
  wire cfg_hit = wr_en && wr_off[6:5] == `GP_CFG_TOP;
  wire sel_hit = wr_en && wr_off[6:4] == `GP_BANK_SEL;
  wire [31:0] drive_enable_next = apply(drive_enable_reg, wr_data, wr_mask, wr_act);
  wire [31:0] level_next = apply(level_reg, wr_data, wr_mask, wr_act);

  // Read mux; strobe words are write-only and read zero
  function automatic logic [31:0] rd_word(input logic [6:0] off);
    logic [4:0] cb;
    logic [3:0] sb;
    cb = {off[4:2], 2'h0};
    sb = {off[3:2], 2'h0};
    if (off == `GP_OFF_DIR) rd_word = drive_enable_reg;
    else if (off == `GP_OFF_OUT) rd_word = level_reg;
    else if (off == `GP_OFF_IN) rd_word = sync_level;
    else if (off == `GP_OFF_CTRL) rd_word = always_sync_reg;
    else if (off[6:5] == `GP_CFG_TOP)
      rd_word = {pad_config_reg[cb + 5'h3], pad_config_reg[cb + 5'h2],
                 pad_config_reg[cb + 5'h1], pad_config_reg[cb]};
    else if (off[6:4] == `GP_BANK_SEL)
      rd_word = {sel_reg[sb + 4'h3], sel_reg[sb + 4'h2], sel_reg[sb + 4'h1], sel_reg[sb]};
    else rd_word = `GP_RST_WORD;
  endfunction

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_enable_reg <= `GP_RST_WORD;
      level_reg <= `GP_RST_WORD;
      always_sync_reg <= `GP_RST_WORD;
    end else begin
      if (dir_hit) drive_enable_reg <= drive_enable_next;
      if (out_hit) level_reg <= level_next;
      if (ctrl_hit) always_sync_reg <= apply(always_sync_reg, wr_data, wr_mask, ACT_WRITE);
    end
  end

  // Byte-wide configuration stores, one lane per byte enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) pad_config_reg[i] <= `GP_RST_BYTE;
      for (int i = 0; i < 16; i++) sel_reg[i] <= `GP_RST_BYTE;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_hit && wr_be[b]) pad_config_reg[{wr_off[4:2], 2'(b)}] <= wr_data[8*b +: 8];
        if (sel_hit && wr_be[b]) sel_reg[{wr_off[3:2], 2'(b)}] <= wr_data[8*b +: 8];
      end
    end
  end

  // ****************************************************************
  // Bus handshakes and read data
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_reg <= 2'h0;
      pready_reg <= 1'b0;
      prdata_reg <= `GP_RST_WORD;
      lp_rdata_reg <= `GP_RST_WORD;
    end else begin
      wait_cnt_reg <= (demand && !sync_done) ? wait_cnt_reg + 2'h1 :
                      (apb_access ? wait_cnt_reg : 2'h0);
      pready_reg <= apb_go;
      if (apb_go && !pwrite) prdata_reg <= apb_hit ? rd_word(apb_off) : `GP_RST_WORD;
      // No wait states: the local port is answered on the next edge regardless
      if (lp_valid && !lp_write) lp_rdata_reg <= lp_ok ? rd_word(lp_off) : `GP_RST_WORD;
    end
  end

  // ****************************************************************
  // Pad drive, pull and receiver
  // ****************************************************************
  wire [31:0] oe_next = (drive_enable_reg & ~afe_vec) | (periph_oe & afe_vec);
  wire [31:0] out_next = (level_reg & ~afe_vec) | (periph_out & afe_vec);
  // Pull only on non-driven general pins; driver on kills the pull
  wire [31:0] pull_next = pull_vec & ~afe_vec & ~drive_enable_reg;
  wire [31:0] rx_next = rx_vec & ~afe_vec;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe_reg <= `GP_RST_WORD;
      pad_out_reg <= `GP_RST_WORD;
      rx_reg <= `GP_RST_WORD;
      pull_en_reg <= `GP_RST_WORD;
      pull_up_reg <= `GP_RST_WORD;
    end else begin
      pad_oe_reg <= oe_next;
      pad_out_reg <= out_next;
      rx_reg <= rx_next;
      pull_en_reg <= pull_next;
      pull_up_reg <= level_reg;
    end
  end

  // Even pin takes the low nibble of its pair's byte, odd pin the high nibble
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_sel_reg <= {4{`GP_RST_WORD}};
    end else begin
      for (int p = 0; p < 32; p++) alt_sel_reg[4*p +: 4] <= sel_reg[p/2][4*(p%2) +: 4];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign lp_rdata = lp_rdata_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pad_rx_en = rx_reg;
  assign pad_pull_en = pull_en_reg;
  assign pad_pull_up = pull_up_reg;
  assign alt_function_select = alt_sel_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_in_start;
    apb_in_rd && needs_sync && wait_cnt_reg == 2'h0;
  endsequence
  sequence s_held_two;
    !apb_go [*2];
  endsequence

  property p_oe_dir;
    (!afe_vec[0]) |=> (pad_oe[0] == $past(drive_enable_reg[0]));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("Pin 0 drive mismatch");

  property p_level;
    (!afe_vec[0] && drive_enable_reg[0]) |=> (pad_oe[0] && pad_out[0] == $past(level_reg[0]));
  endproperty
  a_level: assert property (p_level) else $error("Pin 0 level mismatch");

  property p_rx_off;
    (!rx_vec[0]) |=> $stable(sync_level[0]);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("Disabled receiver sampled");

  property p_dset;
    (wr_en && wr_off == `GP_OFF_DRV_SET) |=>
      drive_enable_reg == ($past(drive_enable_reg) | ($past(wr_data) & $past(wr_mask)));
  endproperty
  a_dset: assert property (p_dset) else $error("Drive set strobe wrong");

  property p_dclr;
    (wr_en && wr_off == `GP_OFF_DRV_CLR) |=>
      drive_enable_reg == ($past(drive_enable_reg) & ~($past(wr_data) & $past(wr_mask)));
  endproperty
  a_dclr: assert property (p_dclr) else $error("Drive clear strobe wrong");

  property p_tgl;
    (wr_en && wr_off == `GP_OFF_LVL_TGL) |=>
      level_reg == ($past(level_reg) ^ ($past(wr_data) & $past(wr_mask)));
  endproperty
  a_tgl: assert property (p_tgl) else $error("Level toggle wrong");

  property p_sync_wait;
    s_in_start |-> s_held_two;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("Input read not delayed");

  property p_always;
    (apb_in_rd && !needs_sync && !lp_valid) |-> apb_go ##1 pready;
  endproperty
  a_always: assert property (p_always) else $error("Always-sync read delayed");

  property p_prio;
    (apb_access && lp_valid) |-> !apb_go;
  endproperty
  a_prio: assert property (p_prio) else $error("APB served over local port");

  property p_pull_off;
    (pad_oe & pad_pull_en) == `GP_RST_WORD;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("Pull on driven pin");

endmodule

// ==== test/cpu_bus_model.sv ====
// Processor core model: APB master and core local port master
module cpu_bus_model (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Core local port master side
  output logic lp_valid,
  output logic lp_write,
  output logic [11:0] lp_addr,
  output logic [31:0] lp_wdata,
  output logic [3:0] lp_be,
  input wire logic [31:0] lp_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Idle levels
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {lp_valid, lp_write, lp_addr, lp_wdata, lp_be} = '0;
  end

  // APB transfer held until pready is seen; n counts edges from access phase
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output int n);
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Bounded so a stuck slave shows up as a wrong count, not a hang
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Local port access: one cycle request, never waits, data on the next cycle
  task automatic lp(input logic wr, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    lp_valid <= 1'b1;
    lp_write <= wr;
    lp_addr <= a;
    lp_wdata <= d;
    lp_be <= 4'hF;
    @(posedge clk);
    lp_valid <= 1'b0;
    @(posedge clk);
    q = lp_rdata;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the pad controller
`include "gpio_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, rst_n, psel, penable, pwrite, pready, lp_valid, lp_write;
  logic [11:0] paddr, lp_addr;
  logic [3:0] pstrb, lp_be;
  logic [31:0] pwdata, prdata, lp_wdata, lp_rdata, ext_drv, periph_out, periph_oe;
  logic [31:0] pad_out, pad_oe, pad_rx_en, pad_pull_en, pad_pull_up, rd, q2;
  logic [127:0] sel_bus;
  wire [31:0] pad_in;
  int cyc, fail_count = 0, total_checks = 0;

  // Pin level: the controller wins where it drives, else the outside source
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  gpio_pad_controller #(.GROUP_INDEX(5'h00)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .lp_valid(lp_valid), .lp_write(lp_write), .lp_addr(lp_addr), .lp_wdata(lp_wdata),
    .lp_be(lp_be), .lp_rdata(lp_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_rx_en(pad_rx_en), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .periph_out(periph_out), .periph_oe(periph_oe),
    .alt_function_select(sel_bus));

  cpu_bus_model cpu_u (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .lp_valid(lp_valid), .lp_write(lp_write), .lp_addr(lp_addr), .lp_wdata(lp_wdata),
    .lp_be(lp_be), .lp_rdata(lp_rdata));

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic aw(input logic [6:0] o, input logic [31:0] d, input logic [3:0] s);
    cpu_u.apb(1'b1, {5'h00, o}, d, s, q2, cyc);
  endtask

  task automatic ar(input logic [6:0] o);
    cpu_u.apb(1'b0, {5'h00, o}, 32'h0, 4'h0, rd, cyc);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cyc(input string nm, input int e, input int g);
    total_checks++;
    if (g != e) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b1;
    ext_drv = 32'h0000_0000;
    periph_out = 32'h0000_0000;
    periph_oe = 32'h0000_0000;
    // Reset falls after time zero so the asynchronous branch surely sees an edge
    #1;
    rst_n = 1'b0;
    // Before any clock edge the pads must already be safe
    #1;
    chk("oe_rst", 32'h0, pad_oe);
    chk("rx_rst", 32'h0, pad_rx_en);
    chk("pull_rst", 32'h0, pad_pull_en);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Direction word, then set and clear strobes touching only marked pins
    aw(`GP_OFF_DIR, 32'h0000_00F0, 4'hF);
    aw(`GP_OFF_DRV_SET, 32'h0000_000F, 4'hF);
    aw(`GP_OFF_DRV_CLR, 32'h0000_0003, 4'hF);
    ar(`GP_OFF_DIR);
    chk("dir", 32'h0000_00FC, rd);
    chk_cyc("rd_wait", 2, cyc);
    chk("oe", 32'h0000_00FC, pad_oe);
    // Level strobes in sequence: A5, clear 05, invert low byte
    aw(`GP_OFF_OUT, 32'h0000_0000, 4'hF);
    aw(`GP_OFF_LVL_SET, 32'h0000_00A5, 4'hF);
    aw(`GP_OFF_LVL_CLR, 32'h0000_0005, 4'hF);
    aw(`GP_OFF_LVL_TGL, 32'h0000_00FF, 4'hF);
    ar(`GP_OFF_OUT);
    chk("out", 32'h0000_005F, rd);
    chk("pad_out", 32'h0000_005C, pad_out & pad_oe);
    ar(`GP_OFF_LVL_SET);
    chk("strobe_rd", 32'h0, rd);
    aw(`GP_OFF_OUT, 32'hFFFF_FFFF, 4'b0010);
    ar(`GP_OFF_OUT);
    chk("out_lane", 32'h0000_FF5F, rd);
    // Pins 0 and 2 get receiver and pull; pin 2 drives so its pull must drop
    aw(`GP_OFF_CFG, 32'h0006_0006, 4'b0101);
    repeat (2) @(posedge clk);
    chk("pull_en", 32'h0000_0001, pad_pull_en & 32'h0000_0005);
    chk("pull_up", 32'h0000_0001, pad_pull_up & 32'h0000_0001);
    chk("rx_en", 32'h0000_0005, pad_rx_en);
    aw(`GP_OFF_LVL_CLR, 32'h0000_0001, 4'hF);
    repeat (2) @(posedge clk);
    chk("pull_dn", 32'h0000_0000, pad_pull_up & 32'h0000_0001);
    // On-demand sync: pin 2 reads its own drive, unreceived pins read 0
    ext_drv <= 32'hFFFF_FFFB;
    ar(`GP_OFF_IN);
    chk("in", 32'h0000_0005, rd);
    chk_cyc("in_wait", 4, cyc);
    // Only byte 0 kept in sync: local port sees pin 0 fall, APB still waits
    aw(`GP_OFF_CTRL, 32'h0000_00FF, 4'hF);
    ext_drv <= 32'hFFFF_FFFA;
    repeat (3) @(posedge clk);
    cpu_u.lp(1'b0, {5'h00, `GP_OFF_IN}, 32'h0, rd);
    chk("lp_in", 32'h0000_0004, rd);
    ar(`GP_OFF_IN);
    chk_cyc("in_part", 4, cyc);
    aw(`GP_OFF_CTRL, 32'hFFFF_FFFF, 4'hF);
    ar(`GP_OFF_IN);
    chk_cyc("in_sync", 2, cyc);
    // Local port write and read, plus an offset it does not serve
    cpu_u.lp(1'b1, {5'h00, `GP_OFF_DRV_SET}, 32'h0000_0100, rd);
    cpu_u.lp(1'b0, {5'h00, `GP_OFF_DIR}, 32'h0, rd);
    chk("lp_dir", 32'h0000_01FC, rd);
    cpu_u.lp(1'b0, {5'h00, `GP_OFF_CFG}, 32'h0, rd);
    chk("lp_cfg", 32'h0, rd);
    // Local port request in the APB access cycle pushes APB one cycle out
    fork
      ar(`GP_OFF_DIR);
      begin
        @(posedge clk);
        cpu_u.lp(1'b1, {5'h00, `GP_OFF_DRV_SET}, 32'h0000_0200, q2);
      end
    join
    chk_cyc("apb_held", 3, cyc);
    ar(`GP_OFF_DIR);
    chk("dir_both", 32'h0000_03FC, rd);
    // Direction toggle strobe inverts only the marked pins
    aw(`GP_OFF_DRV_TGL, 32'h0000_0C00, 4'hF);
    ar(`GP_OFF_DIR);
    chk("dir_tgl", 32'h0000_0FFC, rd);
    // Pin 4 handed to a peripheral that drives it low while the level bit is 1
    periph_oe <= 32'h0000_0010;
    aw(`GP_OFF_CFG + 7'h04, 32'h0000_0003, 4'b0001);
    repeat (2) @(posedge clk);
    chk("alt_oe", 32'h0000_0010, pad_oe & 32'h0000_0010);
    chk("alt_out", 32'h0, pad_out & 32'h0000_0010);
    chk("alt_rx", 32'h0, pad_rx_en & 32'h0000_0010);
    periph_oe <= 32'h0000_0000;
    repeat (2) @(posedge clk);
    chk("alt_off", 32'h0, pad_oe & 32'h0000_0010);
    // Selector byte for pins 4 and 5
    aw(`GP_OFF_SEL, 32'h0073_0000, 4'b0100);
    ar(`GP_OFF_SEL);
    chk("sel_rd", 32'h0073_0000, rd);
    chk("sel_out", 32'h0000_0073, {24'h0, sel_bus[23:16]});
    // Another group's window and an unmapped offset are ignored
    cpu_u.apb(1'b1, {5'h01, `GP_OFF_DIR}, 32'hFFFF_FFFF, 4'hF, q2, cyc);
    ar(`GP_OFF_DIR);
    chk("grp", 32'h0000_0FFC, rd);
    ar(7'h28);
    chk("unmapped", 32'h0, rd);
    give_verdict();
  end
endmodule
